/* File: hdl/rcad_pkg.sv */
package rcad_pkg;

  // Datapath and memory geometry
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int RAM_BYTES = 256;

  // Instruction cycle timing at the nominal processor clock
  localparam real INSTR_CYCLE_NS = 166.6667;
  localparam real CORE_CLK_MHZ = 24.0;
  localparam int OSC_PER_INSTR = int'(INSTR_CYCLE_NS * CORE_CLK_MHZ / 1000.0);
  // This core retires one instruction cycle per clk edge, whatever the rate
  localparam int CLK_PER_INSTR = 1;

  // Special function register file addresses (low seven bits)
  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] ADDR_PC_LOW = 7'h02;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [6:0] ADDR_POINTER = 7'h04;
  localparam logic [6:0] ADDR_PC_LATCH = 7'h0a;

  // Status register bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_HALF = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_BANK = 5;

  // Values after reset
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] POINTER_RST = 8'h00;
  localparam logic [4:0] PC_LATCH_RST = 5'h00;
  localparam logic [2:0] SP_RST = 3'h0;
  localparam logic [7:0] RAM_RST = 8'h00;

  // Arithmetic unit operations
  typedef enum logic [3:0] {
    ALU_PASS_A, ALU_PASS_B, ALU_CLR, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR,
    ALU_COM, ALU_INC, ALU_DEC, ALU_RRF, ALU_RLF, ALU_SWAP
  } rcad_alu_op_t;

endpackage : rcad_pkg

/* File: hdl/rcad_alu.sv */
`timescale 1ns/1ps
module rcad_alu
  import rcad_pkg::*;
(
  input wire rcad_alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output logic [7:0] y,
  output logic c,
  output logic dc,
  output logic z
);

  logic [8:0] full;
  logic [4:0] low;

  // Eight-bit two's complement arithmetic, shifts and logic
  always_comb begin
    full = 9'h000;
    low = 5'h00;
    y = b;
    c = cin;
    dc = 1'b0;
    case (op)
      ALU_PASS_A: y = a;
      ALU_PASS_B: y = b;
      ALU_CLR: y = 8'h00;
      ALU_ADD: begin
        full = {1'b0, b} + {1'b0, a};
        low = {1'b0, b[3:0]} + {1'b0, a[3:0]};
        y = full[7:0];
        c = full[8];
        dc = low[4];
      end
      ALU_SUB: begin
        // Carry out of b + ~a + 1 is the inverted borrow
        full = {1'b0, b} + {1'b0, ~a} + 9'h001;
        low = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
        y = full[7:0];
        c = full[8];
        dc = low[4];
      end
      ALU_AND: y = a & b;
      ALU_OR: y = a | b;
      ALU_XOR: y = a ^ b;
      ALU_COM: y = ~b;
      ALU_INC: y = b + 8'h01;
      ALU_DEC: y = b - 8'h01;
      // Rotates run through the carry
      ALU_RRF: begin
        y = {cin, b[7:1]};
        c = b[0];
      end
      ALU_RLF: begin
        y = {b[6:0], cin};
        c = b[7];
      end
      ALU_SWAP: y = {b[3:0], b[7:4]};
      default: y = b;
    endcase
    z = (y == 8'h00);
  end

endmodule : rcad_alu

/* File: hdl/rcad_core.sv */
// Operation
// (RULE1) Instruction words are 14 bits on their own bus; data is 8 bits.
// (RULE2) Instructions take one cycle; branches take two.
// (RULE3) One instruction fetched per cycle, overlapped with executing the previous one.
// (RULE4) Hardware return-address stack of eight entries.
// (RULE5) ALU is 8 bits: add, subtract, shift and bitwise logic.
// (RULE6) Arithmetic works on two's complement values.
// (RULE7) Two-operand ops use W and a file register or literal.
// (RULE8) Single-operand ops use W or a file register.
// (RULE9) W is an 8-bit accumulator with no data address.
// (RULE10) Instructions update carry, half carry and zero in status.
// (RULE11) In subtraction carry is borrow and half carry is digit borrow.
// (RULE12) Special registers, program counter included, sit in data space.
// (RULE13) Direct and indirect addressing of data memory.
// (RULE14) Any operation works on any register in any addressing mode.
// (RULE15) Data memory holds 256 bytes of general storage.
// (RULE16) Decoder implements 35 single-word instructions.
// (RULE17) One instruction cycle is 166.6667 ns at 24 MHz; the core takes one clk edge per instruction cycle, not four.
// (RULE18) Taken branch discards the fetched word and refetches from target.
// (RULE19) Flags become visible to the next instruction with the result write.
`timescale 1ns/1ps
module rcad_core
  import rcad_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [13:0] prog_data,
  output logic [12:0] prog_addr,
  output logic [7:0] work_q,
  output logic [7:0] status_q,
  output logic exec_valid
);

  typedef struct packed {
    logic [12:0] pc;
    logic [13:0] ir;
    logic irv;
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] ptr;
    logic [4:0] pclath;
    logic [2:0] sp;
    logic [7:0][12:0] stack;
    logic [255:0][7:0] ram;
  } rcad_state_t;

  localparam rcad_state_t STATE_RST = '{
    pc: PC_RST, ir: 14'h0000, irv: 1'b0, w: W_RST, status: STATUS_RST, ptr: POINTER_RST,
    pclath: PC_LATCH_RST, sp: SP_RST, stack: '0, ram: {RAM_BYTES{RAM_RST}}
  };

  rcad_state_t st_reg;
  rcad_state_t st_next;

  rcad_alu_op_t alu_op;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_y;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic [7:0] daddr;
  logic [7:0] fval;
  logic [7:0] mask;
  logic to_f;
  logic to_w;
  logic fl_c;
  logic fl_dc;
  logic fl_z;
  logic jump;
  logic skip;
  logic push;
  logic pop;
  logic [12:0] tgt;

  ////////////////////////////////////////////////////////////////////////
  // Data space read: special registers mirror into both banks

  function automatic logic [7:0] rd_byte(input rcad_state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = s.ram[a]; // RULE15
    if (a[6:0] == ADDR_INDIRECT) begin
      v = 8'h00; // Indirect through the indirect slot itself reads zero
    end else if (a[6:0] == ADDR_PC_LOW) begin
      v = s.pc[7:0]; // RULE12
    end else if (a[6:0] == ADDR_STATUS) begin
      v = s.status;
    end else if (a[6:0] == ADDR_POINTER) begin
      v = s.ptr;
    end else if (a[6:0] == ADDR_PC_LATCH) begin
      v = {3'h0, s.pclath};
    end
    return v;
  endfunction : rd_byte

  rcad_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .cin(st_reg.status[ST_CARRY]),
    .y(alu_y),
    .c(alu_c),
    .dc(alu_dc),
    .z(alu_z)
  ); // RULE5 RULE6

  ////////////////////////////////////////////////////////////////////////
  // Decode and execute the held word while the next one is fetched

  always_comb begin
    st_next = st_reg;
    st_next.ir = prog_data; // RULE1 RULE3
    st_next.irv = 1'b1;
    st_next.pc = st_reg.pc + 13'h0001;
    // Indirect when the file field names the indirect slot
    daddr = (st_reg.ir[6:0] == ADDR_INDIRECT) ? st_reg.ptr : {st_reg.status[ST_BANK], st_reg.ir[6:0]}; // RULE13
    fval = rd_byte(st_reg, daddr); // RULE14
    mask = 8'h01 << st_reg.ir[9:7];
    alu_op = ALU_PASS_B;
    alu_a = st_reg.w; // RULE7 RULE8
    alu_b = fval;
    to_f = 1'b0;
    to_w = 1'b0;
    fl_c = 1'b0;
    fl_dc = 1'b0;
    fl_z = 1'b0;
    jump = 1'b0;
    skip = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    tgt = st_reg.pc;
    if (st_reg.irv) begin
      case (st_reg.ir[13:12]) // RULE16
        2'b00: begin
          to_f = st_reg.ir[7];
          to_w = !st_reg.ir[7];
          case (st_reg.ir[11:8])
            4'h0: begin
              to_w = 1'b0;
              alu_op = ALU_PASS_A;
              // Return and return-from-interrupt; sleep and watchdog clear act as no-ops
              pop = !st_reg.ir[7] && (st_reg.ir[6:1] == 6'h04);
            end
            4'h1: begin
              alu_op = ALU_CLR;
              fl_z = 1'b1;
            end
            4'h2: begin
              alu_op = ALU_SUB; // RULE11
              {fl_c, fl_dc, fl_z} = 3'b111;
            end
            4'h3: begin
              alu_op = ALU_DEC;
              fl_z = 1'b1;
            end
            4'h4: begin
              alu_op = ALU_OR;
              fl_z = 1'b1;
            end
            4'h5: begin
              alu_op = ALU_AND;
              fl_z = 1'b1;
            end
            4'h6: begin
              alu_op = ALU_XOR;
              fl_z = 1'b1;
            end
            4'h7: begin
              alu_op = ALU_ADD;
              {fl_c, fl_dc, fl_z} = 3'b111;
            end
            4'h8: fl_z = 1'b1;
            4'h9: begin
              alu_op = ALU_COM;
              fl_z = 1'b1;
            end
            4'ha: begin
              alu_op = ALU_INC;
              fl_z = 1'b1;
            end
            4'hb: begin
              alu_op = ALU_DEC;
              skip = alu_z;
            end
            4'hc: begin
              alu_op = ALU_RRF;
              fl_c = 1'b1;
            end
            4'hd: begin
              alu_op = ALU_RLF;
              fl_c = 1'b1;
            end
            4'he: alu_op = ALU_SWAP;
            default: begin
              alu_op = ALU_INC;
              skip = alu_z;
            end
          endcase
        end
        2'b01: begin
          // Bit clear, set and the two bit tests
          case (st_reg.ir[11:10])
            2'b00: begin
              alu_op = ALU_AND;
              alu_a = ~mask;
              to_f = 1'b1;
            end
            2'b01: begin
              alu_op = ALU_OR;
              alu_a = mask;
              to_f = 1'b1;
            end
            2'b10: skip = ((fval & mask) == 8'h00);
            default: skip = ((fval & mask) != 8'h00);
          endcase
        end
        2'b10: begin
          jump = 1'b1;
          push = !st_reg.ir[11];
          tgt = {st_reg.pclath[4:3], st_reg.ir[10:0]};
        end
        default: begin
          alu_b = st_reg.ir[7:0];
          to_w = 1'b1;
          casez (st_reg.ir[11:8])
            4'b00??: alu_op = ALU_PASS_B;
            4'b01??: pop = 1'b1;
            4'b1000: begin
              alu_op = ALU_OR;
              fl_z = 1'b1;
            end
            4'b1001: begin
              alu_op = ALU_AND;
              fl_z = 1'b1;
            end
            4'b1010: begin
              alu_op = ALU_XOR;
              fl_z = 1'b1;
            end
            4'b110?: begin
              alu_op = ALU_SUB; // RULE11
              {fl_c, fl_dc, fl_z} = 3'b111;
            end
            default: begin
              alu_op = ALU_ADD;
              {fl_c, fl_dc, fl_z} = 3'b111;
            end
          endcase
        end
      endcase
    end
    // Accumulator has no data address, so only to_w reaches it
    if (to_w) begin
      st_next.w = alu_y; // RULE9
    end
    if (to_f) begin
      if (daddr[6:0] == ADDR_INDIRECT) begin
        st_next.w = st_next.w; // Indirect through itself writes nothing
      end else if (daddr[6:0] == ADDR_PC_LOW) begin
        jump = 1'b1; // RULE12
        tgt = {st_reg.pclath, alu_y};
      end else if (daddr[6:0] == ADDR_STATUS) begin
        st_next.status = alu_y;
      end else if (daddr[6:0] == ADDR_POINTER) begin
        st_next.ptr = alu_y;
      end else if (daddr[6:0] == ADDR_PC_LATCH) begin
        st_next.pclath = alu_y[4:0];
      end else begin
        st_next.ram[daddr] = alu_y; // RULE15
      end
    end
    // Flags override a status write from the same instruction
    if (fl_c) begin
      st_next.status[ST_CARRY] = alu_c; // RULE10 RULE19
    end
    if (fl_dc) begin
      st_next.status[ST_HALF] = alu_dc; // RULE10
    end
    if (fl_z) begin
      st_next.status[ST_ZERO] = alu_z; // RULE10
    end
    // Stack wraps silently; pc already points past the call
    if (push) begin
      st_next.stack[st_reg.sp] = st_reg.pc; // RULE4
      st_next.sp = st_reg.sp + 3'h1;
    end
    if (pop) begin
      jump = 1'b1;
      tgt = st_reg.stack[st_reg.sp - 3'h1]; // RULE4
      st_next.sp = st_reg.sp - 3'h1;
    end
    // Taken branch or skip voids the word fetched behind it
    if (jump) begin
      st_next.pc = tgt; // RULE18
      st_next.irv = 1'b0; // RULE2
    end else if (skip) begin
      st_next.irv = 1'b0; // RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; one clk edge per instruction cycle

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= STATE_RST;
    end else if (ce) begin
      st_reg <= st_next; // RULE17
    end
  end

  assign prog_addr = st_reg.pc;
  assign work_q = st_reg.w;
  assign status_q = st_reg.status;
  assign exec_valid = st_reg.irv;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_call;
    ce && st_reg.irv && (st_reg.ir[13:11] == 3'b100);
  endsequence

  sequence s_skip;
    ce && skip && !jump ##1 ce;
  endsequence

  a_fetch_load: assert property (ce |=> st_reg.ir == $past(prog_data)) // RULE3
    else $error("fetched word not loaded");
  a_branch_refetch: assert property (ce && jump |=> !st_reg.irv && st_reg.pc == $past(tgt)) // RULE18
    else $error("branch did not refetch from target");
  a_single_cycle: assert property (ce && !jump && !skip |=> st_reg.irv) // RULE2
    else $error("plain instruction lost a cycle");
  a_skip_two: assert property (s_skip |-> !st_reg.irv ##1 st_reg.irv) // RULE2
    else $error("skip did not take two cycles");
  a_call_push: assert property (s_call |=> st_reg.sp == $past(st_reg.sp) + 3'h1) // RULE4
    else $error("call did not push");
  a_zero_flag: assert property (ce && fl_z |=> st_reg.status[ST_ZERO] == ($past(alu_y) == 8'h00)) // RULE10
    else $error("zero flag wrong");
  a_borrow_flag: assert property (ce && fl_c && alu_op == ALU_SUB |=> // RULE11
    st_reg.status[ST_CARRY] == ($past(alu_b) >= $past(alu_a)))
    else $error("borrow flag wrong");
  a_half_borrow: assert property (ce && fl_dc && alu_op == ALU_SUB |=> // RULE11
    st_reg.status[ST_HALF] == ($past(alu_b[3:0]) >= $past(alu_a[3:0])))
    else $error("digit borrow wrong");
  a_work_write: assert property (ce && to_w |=> st_reg.w == $past(alu_y)) // RULE9
    else $error("accumulator not written");

endmodule : rcad_core

/* File: sim/rcad_prog_mem.sv */
`timescale 1ns/1ps
module rcad_prog_mem
  import rcad_pkg::*;
(
  input wire logic [12:0] addr,
  output logic [13:0] data
);
  ////////////////////////////////////////////////////////////////////////////
  // Program store
  logic [13:0] rom [0:8191];

  // Unwritten words read as no-op, so a stray fetch stays harmless
  initial begin
    for (int i = 0; i < 8192; i++) begin
      rom[i] = 14'h0000;
    end
  end

  // Combinational read, word valid in the cycle it is addressed
  assign data = rom[addr];
endmodule : rcad_prog_mem

/* File: sim/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b0;
  logic [13:0] prog_data;
  logic [12:0] prog_addr;
  logic [7:0] work_q;
  logic [7:0] status_q;
  logic exec_valid;
  int errors = 0;
  int check_count = 0;
  logic [28:0] q[$];
  logic [12:0] pa = 13'h0000;
  logic [7:0] w = 8'h00;
  logic [7:0] s = 8'h00;
  logic ev = 1'b0;
  logic fz = 1'b0;
  logic [12:0] pn = 13'h0000;

  // 10 MHz processor clock
  always #50 clk = ~clk;

  rcad_core rcad_core_inst (.clk(clk), .rst(rst), .ce(ce), .prog_data(prog_data), .prog_addr(prog_addr),
    .work_q(work_q), .status_q(status_q), .exec_valid(exec_valid));
  rcad_prog_mem rcad_prog_mem_inst (.addr(prog_addr), .data(prog_data));

  ////////////////////////////////////////////////////////////////////////////
  // Program builder: each placed word notes the state after it executes
  task automatic put(input logic [12:0] a, input logic [13:0] d);
    rcad_prog_mem_inst.rom[a] = d;
  endtask : put

  task automatic op(input logic [13:0] ins, input logic [12:0] nx, input logic tk);
    put(pa, ins);
    // Poison behind a taken branch: executing it would corrupt W
    if (tk) begin
      put(pa + 13'h1, 14'h30ee);
    end
    q.push_back({w, s, tk ? nx : nx + 13'h1});
    pa = nx;
  endtask : op

  task automatic step(input logic [13:0] ins);
    op(ins, pa + 13'h1, 1'b0);
  endtask : step

  task automatic stop_test();
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: sample mid-cycle, away from the edge that updates outputs
  always @(negedge clk) begin
    ev = !rst && ce && exec_valid === 1'b1;
    fz = !rst && !ce;
    pn = prog_addr;
  end

  // One note per executed word; bubbles pop nothing
  always @(posedge clk) begin
    logic [28:0] e;
    if (ev && q.size() > 0) begin
      e = q.pop_front();
      #1;
      `CHK("work", e[28:21], work_q)
      `CHK("status", e[20:13], status_q)
      `CHK("fetch", e[12:0], prog_addr)
    end else if (fz) begin
      #1;
      `CHK("frozen", pn, prog_addr)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] m;
    logic [8:0] t;
    logic [12:0] r [8];
    int i;
    #1;
    void'($urandom(32'h5d97));
    x = 8'($urandom());
    y = 8'($urandom());
    m = 8'($urandom());
    // Literal arithmetic and logic on random operands
    w = x;
    step({6'h30, x});
    t = {1'b0, w} + {1'b0, y};
    s[0] = t[8];
    s[1] = ({1'b0, w[3:0]} + {1'b0, y[3:0]}) > 5'h0f;
    s[2] = t[7:0] == 8'h00;
    w = t[7:0];
    step({6'h3e, y});
    s[0] = m >= w;
    s[1] = m[3:0] >= w[3:0];
    w = m - w;
    s[2] = w == 8'h00;
    step({6'h3c, m});
    w = w & x;
    s[2] = w == 8'h00;
    step({6'h39, x});
    w = w | y;
    s[2] = w == 8'h00;
    step({6'h38, y});
    x = w;
    w = 8'h00;
    s[2] = 1'b1;
    step({6'h3a, x});
    // File ops, bank select, pointer and shifts through carry
    w = 8'h5a;
    step(14'h305a);
    step(14'h00a5);
    s[5] = 1'b1;
    step(14'h1683);
    w = 8'h00;
    s[2] = 1'b1;
    step(14'h0825);
    w = 8'h25;
    step(14'h3025);
    step(14'h0084);
    w = 8'h5a;
    s[2] = 1'b0;
    step(14'h0800);
    s[5] = 1'b0;
    step(14'h1283);
    w = {s[0], 7'h2d};
    s[0] = 1'b0;
    step(14'h0c25);
    step(14'h0da5);
    w = 8'hb4;
    step(14'h0825);
    w = 8'h00;
    s[2:0] = 3'b111;
    step(14'h0225);
    w = 8'(pa + 13'h1);
    s[2] = w == 8'h00;
    step(14'h0802);
    // Jump, skip, then eight nested calls unwound by literal returns
    op(14'h2840, 13'h0040, 1'b1);
    w = 8'h01;
    step(14'h3001);
    step(14'h00a6);
    op(14'h0ba6, pa + 13'h2, 1'b1);
    for (i = 0; i < 8; i++) begin
      r[i] = pa + 13'h1;
      op({3'b100, 11'h100 + 11'(i * 16)}, 13'h100 + 13'(i * 16), 1'b1);
    end
    for (i = 7; i >= 0; i--) begin
      w = 8'(i);
      op({6'h34, 8'(i)}, r[i], 1'b1);
    end
    w = 8'h77;
    step(14'h3077);
    // Byte ops through one file register, to file and to W
    x = 8'($urandom());
    w = x;
    step({6'h30, x});
    step(14'h00b0);
    x = x + 8'h01;
    s[2] = x == 8'h00;
    step(14'h0ab0);
    w = ~x;
    s[2] = w == 8'h00;
    step(14'h0930);
    w = {x[3:0], x[7:4]};
    step(14'h0e30);
    x = x - 8'h01;
    s[2] = x == 8'h00;
    step(14'h03b0);
    t = {1'b0, x} + {1'b0, w};
    s[0] = t[8];
    s[1] = ({1'b0, x[3:0]} + {1'b0, w[3:0]}) > 5'h0f;
    s[2] = t[7:0] == 8'h00;
    x = t[7:0];
    step(14'h07b0);
    s[0] = x >= w;
    s[1] = x[3:0] >= w[3:0];
    w = x - w;
    s[2] = w == 8'h00;
    step(14'h0230);
    w = w | x;
    s[2] = w == 8'h00;
    step(14'h0430);
    w = w & x;
    s[2] = w == 8'h00;
    step(14'h0530);
    x = x ^ w;
    s[2] = x == 8'h00;
    step(14'h06b0);
    w = x;
    s[2] = w == 8'h00;
    step(14'h0830);
    x = 8'h00;
    s[2] = 1'b1;
    step(14'h01b0);
    // Skips that fall through and skips that are taken
    x = 8'h01;
    step(14'h0fb0);
    op(14'h1c30, pa + 13'h2, 1'b1);
    step(14'h1830);
    op(14'h18b0, pa + 13'h2, 1'b1);
    w = 8'h00;
    s[2] = 1'b1;
    step(14'h0100);
    w = 8'hff;
    step(14'h30ff);
    step(14'h00b0);
    w = 8'h00;
    op(14'h0f30, pa + 13'h2, 1'b1);
    // Latch supplies the upper bits of jump, call and PC low write targets
    w = 8'h08;
    step(14'h3008);
    step(14'h008a);
    s[2] = 1'b0;
    step(14'h080a);
    op(14'h2810, 13'h0810, 1'b1);
    r[0] = pa + 13'h1;
    op({3'b100, 11'h0e0}, 13'h08e0, 1'b1);
    op(14'h0008, r[0], 1'b1);
    w = 8'h40;
    step(14'h3040);
    op(14'h0082, 13'h0840, 1'b1);
    w = 8'h3c;
    step(14'h303c);
    // Reset held five cycles, outputs cleared
    repeat (5) @(posedge clk);
    #1;
    `CHK("reset", 30'h0, {prog_addr, work_q, status_q, exec_valid})
    rst = 1'b0;
    // Random clock enable stalls the pipeline between runs
    for (i = 0; i < 3000 && q.size() > 0; i++) begin
      @(posedge clk);
      #1;
      ce = ($urandom() % 4) != 0;
    end
    `CHK("pending", 0, q.size())
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule : tb
